// ---- pkg/fault_classifier_defines.svh ----
`ifndef FAULT_CLASSIFIER_DEFINES_SVH
`define FAULT_CLASSIFIER_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CTRL_OFF 12'h000
`define STATUS_OFF 12'h004

// ----------------------------------------
// Control field positions and resets
// ----------------------------------------
`define CTRL_GEN_BIT 0
`define CTRL_TCE_BIT 1
`define CTRL_OAS_LSB 8
`define CTRL_OAS_MSB 13
`define CTRL_GEN_RST 1'h0
`define CTRL_TCE_RST 1'h0
`define CTRL_OAS_RST 6'h30

// ----------------------------------------
// Event codes
// ----------------------------------------
`define EVT_NONE 8'h00
`define EVT_TRANSL_FORBID 8'h07
`define EVT_BAD_SUBSTREAM 8'h08
`define EVT_CD_FETCH 8'h09
`define EVT_BAD_CD 8'h0A
`define EVT_WALK_ABORT 8'h0B

// ----------------------------------------
// Encodings and limits
// ----------------------------------------
`define CFG_BYPASS_ALL 3'h4
`define ATS_DISALLOWED 2'h0
`define DSS_SUBSTREAM0 2'h2
`define SHORT_DESC_OAS 6'h28
`define MERGE_IGNORE_MSB 12

`endif

// ---- pkg/fault_classifier_pkg.sv ----
package fault_classifier_pkg;

    // Source of a classification request
    typedef enum logic [1:0] {
        KIND_TXN = 2'b00,
        KIND_CD = 2'b01,
        KIND_WALK = 2'b10
    } kind_t;

    // Fault class reported in records
    typedef enum logic [1:0] {
        CLS_CD = 2'b00,
        CLS_TT = 2'b01,
        CLS_IN = 2'b10
    } class_t;

    // Whole register state of the classifier
    typedef struct packed {
        logic gen;
        logic tce;
        logic [5:0] output_address_size;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic ev_valid;
        logic [7:0] ev_code;
        logic [15:0] ev_sid;
        logic [19:0] ev_ssid;
        logic [51:0] ev_fetch;
        logic [63:0] ev_in;
        logic ev_rnw;
        logic ev_ind;
        logic ev_pnu;
        logic ev_s2;
        class_t ev_class;
        logic [7:0] ev_reason;
        logic ev_ns;
        logic ev_merge;
        logic [15:0] count;
    } state_t;

endpackage

// ---- pkg/addr_fix_if.sv ----
`timescale 1ns/1ps

// Fetch address clean-up path
interface addr_fix_if;
    logic [51:0] raw;
    logic [5:0] output_address_size;
    logic trunc_req;
    logic base_ver;
    logic [51:0] fixed;

    modport user (output raw, output output_address_size, output trunc_req, output base_ver, input fixed);
    modport fixer (input raw, input output_address_size, input trunc_req, input base_ver, output fixed);
endinterface

// ---- rtl/fetch_addr_sanitizer.sv ----
`timescale 1ns/1ps

// ----------------------------------------
// Per-bit masking of a reported fetch address
// ----------------------------------------
module fetch_addr_sanitizer (
    addr_fix_if.fixer af
);
    // Bits at or above the output size and below 48 read zero when truncated,
    // bits 51:48 read zero in base-version parts
    for (genvar i = 0; i < 52; i++) begin : g_bit
        if (i >= 48) begin : g_hi
            assign af.fixed[i] = af.base_ver ? 1'b0 : af.raw[i];
        end else begin : g_lo
            assign af.fixed[i] = (af.trunc_req && (6'(i) >= af.output_address_size)) ? 1'b0 : af.raw[i];
        end
    end
endmodule

// ---- rtl/iommu_fault_event_classifier.sv ----
`timescale 1ns/1ps
`include "fault_classifier_defines.svh"

module iommu_fault_event_classifier #(
    parameter bit BASE_VERSION = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic req_valid,
    input wire fault_classifier_pkg::kind_t req_kind,
    input wire logic [15:0] stream_id,
    input wire logic secure_stream_flag,
    input wire logic req_translated,
    input wire logic ste_valid,
    input wire logic [1:0] ats_permission_field,
    input wire logic [2:0] ste_config,
    input wire logic substream_present,
    input wire logic [19:0] substream_id,
    input wire logic [19:0] context_count_field,
    input wire logic [1:0] default_substream_select,
    input wire logic cd_two_level,
    input wire logic l1_valid,
    input wire logic l2_ptr_bad,
    input wire logic cd_abort,
    input wire logic cd_range_bad,
    input wire logic cd_valid,
    input wire logic cd_illegal,
    input wire logic stage2_enabled,
    input wire logic stage2_secure_attr,
    input wire logic walk_stage2,
    input wire fault_classifier_pkg::class_t walk_source,
    input wire logic short_desc_fetch,
    input wire logic [51:0] fetch_phys_address,
    input wire logic [63:0] incoming_address_field,
    input wire logic read_not_write,
    input wire logic instruction_not_data,
    input wire logic privileged_not_user,
    input wire logic [7:0] cause_code,
    output logic evt_valid,
    output logic [7:0] evt_code,
    output logic [15:0] evt_stream_id,
    output logic [19:0] evt_substream_id,
    output logic [51:0] evt_fetch_addr,
    output logic [63:0] evt_input_addr,
    output logic evt_read_not_write,
    output logic evt_instruction_not_data,
    output logic evt_privileged_not_user,
    output logic evt_stage2_flag,
    output fault_classifier_pkg::class_t evt_class,
    output logic [7:0] evt_reason,
    output logic evt_fetch_ns,
    output logic evt_merge_hit
);
    import fault_classifier_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    state_t st_ff; // Registered state
    state_t nxt_st; // Next state
    addr_fix_if af (); // Address clean-up link

    // Per-request decision terms
    logic forbid; // Translated use not allowed
    logic ssid_bad; // Substream check failed
    logic l1_bad; // Two-level descriptor failed
    logic cd_fail; // Context fetch abort
    logic cd_bad; // Context descriptor unusable
    logic [7:0] code; // Chosen event code
    logic [19:0] rec_ssid; // Substream to record
    class_t rec_class; // Class to record
    logic same_key; // Equal to previous record

    // ----------------------------------------
    // Address clean-up
    // ----------------------------------------
    assign af.raw = fetch_phys_address;
    assign af.output_address_size = st_ff.output_address_size;
    assign af.base_ver = BASE_VERSION;
    // Truncation applies to base-part context fetches and to short walks when the output size is below 40
    assign af.trunc_req = (req_kind == KIND_CD) ? BASE_VERSION
                        : (short_desc_fetch && (st_ff.output_address_size < `SHORT_DESC_OAS));

    fetch_addr_sanitizer u_fix (
        .af(af)
    );

    // ----------------------------------------
    // Condition terms
    // ----------------------------------------
    // Translated transaction that may not bypass
    assign forbid = req_translated && (secure_stream_flag || !st_ff.gen
        || (st_ff.tce && ste_valid
            && (ats_permission_field == `ATS_DISALLOWED || ste_config == `CFG_BYPASS_ALL)));

    // Substream given where none is allowed, or at or above the context count
    assign ssid_bad = substream_present && (!ste_config[0]
        || context_count_field == 20'h00000
        || substream_id >= context_count_field);

    // Level-1 descriptor invalid or pointer out of range
    assign l1_bad = cd_two_level && (!l1_valid || l2_ptr_bad);

    // Context fetch abort, range error only in base parts
    assign cd_fail = cd_abort || (BASE_VERSION && cd_range_bad);

    // Fetched descriptor invalid or illegal
    assign cd_bad = !cd_valid || cd_illegal;

    // ----------------------------------------
    // Event selection
    // ----------------------------------------
    // Fixed priority inside each request kind
    always_comb begin
        code = `EVT_NONE;
        unique case (req_kind)
            KIND_TXN: begin
                if (forbid) begin
                    code = `EVT_TRANSL_FORBID;
                end else if (ssid_bad) begin
                    code = `EVT_BAD_SUBSTREAM;
                end
            end
            KIND_CD: begin
                if (l1_bad) begin
                    code = `EVT_BAD_SUBSTREAM;
                end else if (cd_fail) begin
                    code = `EVT_CD_FETCH;
                end else if (cd_bad) begin
                    code = `EVT_BAD_CD;
                end
            end
            KIND_WALK: begin
                code = `EVT_WALK_ABORT;
            end
            default: begin
                code = `EVT_NONE;
            end
        endcase
    end

    // Intended context index for a bad pointer
    always_comb begin
        rec_ssid = substream_id;
        if (req_kind == KIND_CD && l2_ptr_bad && !substream_present
            && default_substream_select == `DSS_SUBSTREAM0) begin
            rec_ssid = 20'h00000;
        end
    end

    // Class: stage 1 walks are TT, stage 2 by source
    always_comb begin
        rec_class = CLS_TT;
        if (walk_stage2) begin
            rec_class = walk_source;
        end
    end

    // Same event as the last record, page-granular address
    assign same_key = (code == st_ff.ev_code) && (stream_id == st_ff.ev_sid)
        && (incoming_address_field[63:`MERGE_IGNORE_MSB]
            == st_ff.ev_in[63:`MERGE_IGNORE_MSB]);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.ev_valid = 1'b0;
        nxt_st.pready = 1'b0;
        nxt_st.pslverr = 1'b0;

        // APB access phase answered one cycle in
        if (psel && penable && !st_ff.pready) begin
            nxt_st.pready = 1'b1;
            nxt_st.prdata = 32'h00000000;
            unique case (paddr[11:0])
                `CTRL_OFF: begin
                    // Enables and output size
                    if (pwrite && pstrb[0]) begin
                        nxt_st.gen = pwdata[`CTRL_GEN_BIT];
                        nxt_st.tce = pwdata[`CTRL_TCE_BIT];
                    end
                    if (pwrite && pstrb[1]) begin
                        nxt_st.output_address_size = pwdata[`CTRL_OAS_MSB:`CTRL_OAS_LSB];
                    end
                    nxt_st.prdata[`CTRL_GEN_BIT] = st_ff.gen;
                    nxt_st.prdata[`CTRL_TCE_BIT] = st_ff.tce;
                    nxt_st.prdata[`CTRL_OAS_MSB:`CTRL_OAS_LSB] = st_ff.output_address_size;
                end
                `STATUS_OFF: begin
                    // Last code, merge flag, event count
                    if (pwrite) begin
                        nxt_st.count = 16'h0000;
                    end
                    nxt_st.prdata = {st_ff.count, 7'h00, st_ff.ev_merge, st_ff.ev_code};
                end
                default: begin
                    // Unmapped address
                    nxt_st.pslverr = 1'b1;
                end
            endcase
        end

        // Record one event
        if (req_valid && code != `EVT_NONE) begin
            nxt_st.ev_valid = 1'b1;
            nxt_st.ev_code = code;
            nxt_st.ev_sid = stream_id;
            nxt_st.ev_ssid = rec_ssid;
            nxt_st.ev_in = incoming_address_field;
            nxt_st.ev_fetch = 52'h0000000000000;
            nxt_st.ev_rnw = read_not_write;
            nxt_st.ev_ind = read_not_write && instruction_not_data;
            nxt_st.ev_pnu = privileged_not_user;
            nxt_st.ev_s2 = 1'b0;
            nxt_st.ev_class = CLS_IN;
            nxt_st.ev_reason = 8'h00;
            nxt_st.ev_ns = 1'b0;
            nxt_st.ev_merge = same_key && (code == `EVT_TRANSL_FORBID || code == `EVT_WALK_ABORT);
            if (code == `EVT_CD_FETCH) begin
                nxt_st.ev_fetch = af.fixed;
                nxt_st.ev_reason = cause_code;
                // Queue security implies the address space
                nxt_st.ev_ns = !secure_stream_flag
                    || (stage2_enabled && stage2_secure_attr);
            end
            if (code == `EVT_WALK_ABORT) begin
                nxt_st.ev_fetch = af.fixed;
                nxt_st.ev_reason = cause_code;
                nxt_st.ev_s2 = walk_stage2;
                nxt_st.ev_class = rec_class;
            end
            // Count wins over a software clear
            nxt_st.count = st_ff.count + 16'h0001;
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
            st_ff.gen <= `CTRL_GEN_RST;
            st_ff.tce <= `CTRL_TCE_RST;
            st_ff.output_address_size <= `CTRL_OAS_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign pready = st_ff.pready;
    assign prdata = st_ff.prdata;
    assign pslverr = st_ff.pslverr;
    assign evt_valid = st_ff.ev_valid;
    assign evt_code = st_ff.ev_code;
    assign evt_stream_id = st_ff.ev_sid;
    assign evt_substream_id = st_ff.ev_ssid;
    assign evt_fetch_addr = st_ff.ev_fetch;
    assign evt_input_addr = st_ff.ev_in;
    assign evt_read_not_write = st_ff.ev_rnw;
    assign evt_instruction_not_data = st_ff.ev_ind;
    assign evt_privileged_not_user = st_ff.ev_pnu;
    assign evt_stage2_flag = st_ff.ev_s2;
    assign evt_class = st_ff.ev_class;
    assign evt_reason = st_ff.ev_reason;
    assign evt_fetch_ns = st_ff.ev_ns;
    assign evt_merge_hit = st_ff.ev_merge;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Translated request and its record
    sequence s_txn_translated;
        req_valid && req_kind == KIND_TXN && req_translated;
    endsequence

    sequence s_rec(logic [7:0] c);
        evt_valid && evt_code == c;
    endsequence

    a_secure_forbid:
    assert property (s_txn_translated and secure_stream_flag |=> s_rec(`EVT_TRANSL_FORBID))
        else $error("secure translated request not reported");

    a_gen_off_forbid:
    assert property (s_txn_translated and !st_ff.gen |=> s_rec(`EVT_TRANSL_FORBID) ##1 !evt_valid)
        else $error("forbidden event missing with translation off");

    a_check_bypass:
    assert property (s_txn_translated and (st_ff.tce && ste_valid && ste_config == `CFG_BYPASS_ALL)
        |=> s_rec(`EVT_TRANSL_FORBID))
        else $error("bypass configuration not refused");

    a_single_event:
    assert property (s_txn_translated and forbid and ssid_bad |=> not s_rec(`EVT_BAD_SUBSTREAM))
        else $error("lower priority event recorded");

    a_stage1_off_ssid:
    assert property (req_valid && req_kind == KIND_TXN && !req_translated && substream_present
        && !ste_config[0] |=> s_rec(`EVT_BAD_SUBSTREAM) and evt_substream_id == $past(substream_id))
        else $error("substream with stage 1 off not reported");

    a_default_ssid_zero:
    assert property (req_valid && req_kind == KIND_CD && cd_two_level && l2_ptr_bad
        && !substream_present && default_substream_select == `DSS_SUBSTREAM0
        |=> s_rec(`EVT_BAD_SUBSTREAM) and evt_substream_id == 20'h00000)
        else $error("default substream index not zero");

    a_fetch_ns_queue:
    assert property (s_rec(`EVT_CD_FETCH) and !evt_fetch_ns |-> $past(secure_stream_flag))
        else $error("non-secure queue fetch shown secure");

    a_walk_class_s2:
    assert property (req_valid && req_kind == KIND_WALK && walk_stage2
        |=> evt_stage2_flag && evt_class == $past(walk_source))
        else $error("stage 2 walk class wrong");

    a_walk_s1_tt:
    assert property (req_valid && req_kind == KIND_WALK && !walk_stage2
        |=> !evt_stage2_flag && evt_class == CLS_TT && evt_reason == $past(cause_code))
        else $error("stage 1 walk class wrong");

    a_write_ind_zero:
    assert property (evt_valid && evt_code == `EVT_WALK_ABORT && !evt_read_not_write
        |-> !evt_instruction_not_data)
        else $error("instruction bit set on write");

    a_hi_bits_zero:
    assert property (evt_valid && BASE_VERSION |-> evt_fetch_addr[51:48] == 4'h0)
        else $error("fetch bits 51:48 not zero");

    a_merge_low_bits:
    assert property (req_valid && req_kind == KIND_WALK && evt_code == `EVT_WALK_ABORT
        && stream_id == evt_stream_id && incoming_address_field[63:12] == evt_input_addr[63:12]
        |=> evt_merge_hit)
        else $error("page-equal events not merged");

endmodule

// ---- dv/client_requester.sv ----
`timescale 1ns/1ps

// ----------------------------------------
// Upstream client raising classification requests
// ----------------------------------------
module client_requester (
    input wire logic pclk
);
    import fault_classifier_pkg::*;

    logic req_valid; // Request strobe
    kind_t req_kind; // Request source
    class_t walk_source; // Walk address source
    logic [15:0] stream_id;
    logic [19:0] substream_id, context_count_field;
    logic [1:0] ats_permission_field, default_substream_select;
    logic [2:0] ste_config;
    logic [51:0] fetch_phys_address;
    logic [63:0] incoming_address_field;
    logic [7:0] cause_code;
    logic secure_stream_flag, req_translated, ste_valid, substream_present, cd_two_level, l1_valid;
    logic l2_ptr_bad, cd_abort, cd_range_bad, cd_valid, cd_illegal, stage2_enabled, stage2_secure_attr;
    logic walk_stage2, short_desc_fetch, read_not_write, instruction_not_data, privileged_not_user;

    // Quiet, legal field values
    task automatic defaults();
        {req_valid, secure_stream_flag, req_translated, substream_present, cd_two_level} <= 5'h0;
        {l2_ptr_bad, cd_abort, cd_range_bad, cd_illegal, stage2_enabled, short_desc_fetch} <= 6'h0;
        {ste_valid, l1_valid, cd_valid, stage2_secure_attr, walk_stage2} <= 5'h1F;
        {read_not_write, instruction_not_data, privileged_not_user} <= 3'h7;
        req_kind <= KIND_TXN;
        walk_source <= CLS_IN;
        stream_id <= 16'h1234;
        substream_id <= 20'h00005;
        context_count_field <= 20'h00010;
        ats_permission_field <= 2'h1;
        default_substream_select <= 2'h0;
        ste_config <= 3'h1;
        fetch_phys_address <= 52'hA_BCDE_F123_4567;
        incoming_address_field <= 64'h1122_3344_5566_7788;
        cause_code <= 8'h5A;
    endtask

    // One-cycle pulse; every field falls back to quiet values after the edge
    task automatic send();
        req_valid <= 1'h1;
        @(posedge pclk);
        defaults();
    endtask

    initial defaults();
endmodule

// ---- dv/iommu_fault_event_classifier_tb.sv ----
`timescale 1ns/1ps

// ----------------------------------------
// Self-checking bench for the fault classifier
// ----------------------------------------
module iommu_fault_event_classifier_tb;
    import fault_classifier_pkg::*;

    localparam logic [51:0] FA = 52'hA_BCDE_F123_4567; // Default fetch address
    localparam logic [63:0] IA = 64'h1122_3344_5566_7788; // Default input address
    logic pclk, presetn, psel, penable, pwrite, err, pready, pslverr;
    logic [31:0] paddr, pwdata, rdata, prdata;
    logic evt_valid, evt_read_not_write, evt_instruction_not_data, evt_privileged_not_user;
    logic evt_stage2_flag, evt_fetch_ns, evt_merge_hit;
    logic [7:0] evt_code, evt_reason;
    logic [15:0] evt_stream_id;
    logic [19:0] evt_substream_id;
    logic [51:0] evt_fetch_addr;
    logic [63:0] evt_input_addr;
    class_t evt_class;
    int failures, num_checks, cnt;

    client_requester c (.pclk(pclk));

    iommu_fault_event_classifier dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hF), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .req_valid(c.req_valid), .req_kind(c.req_kind), .stream_id(c.stream_id),
        .secure_stream_flag(c.secure_stream_flag), .req_translated(c.req_translated), .ste_valid(c.ste_valid),
        .ats_permission_field(c.ats_permission_field), .ste_config(c.ste_config),
        .substream_present(c.substream_present), .substream_id(c.substream_id),
        .context_count_field(c.context_count_field), .default_substream_select(c.default_substream_select),
        .cd_two_level(c.cd_two_level), .l1_valid(c.l1_valid), .l2_ptr_bad(c.l2_ptr_bad), .cd_abort(c.cd_abort),
        .cd_range_bad(c.cd_range_bad), .cd_valid(c.cd_valid), .cd_illegal(c.cd_illegal),
        .stage2_enabled(c.stage2_enabled), .stage2_secure_attr(c.stage2_secure_attr),
        .walk_stage2(c.walk_stage2), .walk_source(c.walk_source), .short_desc_fetch(c.short_desc_fetch),
        .fetch_phys_address(c.fetch_phys_address), .incoming_address_field(c.incoming_address_field),
        .read_not_write(c.read_not_write), .instruction_not_data(c.instruction_not_data),
        .privileged_not_user(c.privileged_not_user), .cause_code(c.cause_code), .evt_valid(evt_valid),
        .evt_code(evt_code), .evt_stream_id(evt_stream_id), .evt_substream_id(evt_substream_id),
        .evt_fetch_addr(evt_fetch_addr), .evt_input_addr(evt_input_addr),
        .evt_read_not_write(evt_read_not_write), .evt_instruction_not_data(evt_instruction_not_data),
        .evt_privileged_not_user(evt_privileged_not_user), .evt_stage2_flag(evt_stage2_flag),
        .evt_class(evt_class), .evt_reason(evt_reason), .evt_fetch_ns(evt_fetch_ns), .evt_merge_hit(evt_merge_hit)
    );

    // Clock at 25 MHz
    always #20 pclk = ~pclk;

    // ----------------------------------------
    // Checking helpers
    // ----------------------------------------
    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    // Fetch address with every bit at or above lim cleared
    function automatic logic [51:0] fmask(input int lim);
        return FA & ((52'h1 << lim) - 52'h1);
    endfunction

    // APB transfer; data and error taken at the rising edge that sees pready
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        rdata = prdata;
        err = pslverr;
        if (n >= 20) failures++;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic ee);
        apb(1'h0, a, 32'h0000_0000);
        chk("prdata", e, rdata);
        chk("pslverr", ee, err);
    endtask

    // Request kind set one edge after the previous pulse restored the fields
    task automatic step(input kind_t k);
        @(posedge pclk);
        c.req_kind <= k;
    endtask

    // Send one request, look at the record one cycle later
    task automatic fire(input logic [7:0] code);
        c.send();
        #1;
        chk("evt_valid", code != 8'h00, evt_valid);
        if (code != 8'h00) begin
            cnt++;
            chk("evt_code", code, evt_code);
        end
    endtask

    // Verdict and end of run
    task automatic final_report();
        if (failures == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        #(40 * 3000);
        failures++;
        final_report();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {pclk, presetn, psel, penable, pwrite} = 5'h0;
        paddr = 32'h0000_0000;
        pwdata = 32'h0000_0000;
        {failures, num_checks, cnt} = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        rd(32'h0000_0000, 32'h0000_3000, 1'h0);
        rd(32'h0000_0004, 32'h0000_0000, 1'h0);
        rd(32'h0000_0010, 32'h0000_0000, 1'h1);
        step(KIND_TXN); c.req_translated <= 1'h1; fire(8'h07);
        chk("sid", 16'h1234, evt_stream_id);
        apb(1'h1, 32'h0000_0000, 32'h0000_3003);
        step(KIND_TXN); c.req_translated <= 1'h1; fire(8'h00);
        step(KIND_TXN); c.req_translated <= 1'h1; c.ats_permission_field <= 2'h0; fire(8'h07);
        step(KIND_TXN); c.req_translated <= 1'h1; c.ste_config <= 3'h4; fire(8'h07);
        step(KIND_TXN); c.req_translated <= 1'h1; c.secure_stream_flag <= 1'h1; fire(8'h07);
        step(KIND_TXN); c.req_translated <= 1'h1; c.secure_stream_flag <= 1'h1; c.substream_present <= 1'h1;
        c.ste_config <= 3'h0; fire(8'h07);
        step(KIND_TXN); c.substream_present <= 1'h1; c.ste_config <= 3'h0; c.stage2_enabled <= 1'h1;
        fire(8'h08);
        chk("ssid", 20'h00005, evt_substream_id);
        step(KIND_TXN); c.substream_present <= 1'h1; c.context_count_field <= 20'h0; fire(8'h08);
        step(KIND_TXN); c.substream_present <= 1'h1; c.substream_id <= 20'h00010; fire(8'h08);
        step(KIND_TXN); c.substream_present <= 1'h1; c.substream_id <= 20'h0000F; fire(8'h00);
        step(KIND_CD); c.cd_two_level <= 1'h1; c.l1_valid <= 1'h0; c.substream_present <= 1'h1;
        fire(8'h08);
        chk("ssid", 20'h00005, evt_substream_id);
        step(KIND_CD); c.cd_two_level <= 1'h1; c.l2_ptr_bad <= 1'h1; c.default_substream_select <= 2'h2;
        fire(8'h08);
        chk("ssid", 20'h00000, evt_substream_id);
        step(KIND_CD); c.cd_abort <= 1'h1; c.cd_valid <= 1'h0; fire(8'h09);
        chk("reason", 8'h5A, evt_reason);
        chk("fetch", fmask(48), evt_fetch_addr);
        chk("ns", 1'h1, evt_fetch_ns);
        for (int i = 0; i < 2; i++) begin
            step(KIND_CD); c.cd_range_bad <= 1'h1; c.secure_stream_flag <= 1'h1; c.stage2_enabled <= i[0];
            fire(8'h09);
            chk("ns", i[0], evt_fetch_ns);
        end
        step(KIND_CD); c.cd_valid <= 1'h0; fire(8'h0A);
        step(KIND_CD); c.cd_illegal <= 1'h1; fire(8'h0A);
        step(KIND_WALK); c.walk_stage2 <= 1'h0; c.walk_source <= CLS_TT; c.read_not_write <= 1'h0;
        fire(8'h0B);
        chk("rnw", 1'h0, evt_read_not_write);
        chk("ind", 1'h0, evt_instruction_not_data);
        chk("s2", 1'h0, evt_stage2_flag);
        chk("class", CLS_TT, evt_class);
        chk("input", IA, evt_input_addr);
        chk("fetch", fmask(48), evt_fetch_addr);
        chk("reason", 8'h5A, evt_reason);
        for (int i = 0; i < 3; i++) begin
            step(KIND_WALK); c.walk_source <= class_t'(i); fire(8'h0B);
            chk("s2", 1'h1, evt_stage2_flag);
            chk("class", i, evt_class);
            chk("pnu", 1'h1, evt_privileged_not_user);
            chk("ind", 1'h1, evt_instruction_not_data);
        end
        step(KIND_WALK); c.incoming_address_field <= IA ^ 64'h0000_0000_0000_0FFF; fire(8'h0B);
        chk("merge", 1'h1, evt_merge_hit);
        step(KIND_WALK); c.incoming_address_field <= IA ^ 64'h0000_0000_0000_1000; fire(8'h0B);
        chk("merge", 1'h0, evt_merge_hit);
        apb(1'h1, 32'h0000_0000, 32'h0000_2403);
        rd(32'h0000_0000, 32'h0000_2403, 1'h0);
        step(KIND_WALK); c.short_desc_fetch <= 1'h1; fire(8'h0B);
        chk("fetch", fmask(36), evt_fetch_addr);
        step(KIND_CD); c.cd_abort <= 1'h1; fire(8'h09);
        chk("fetch", fmask(36), evt_fetch_addr);
        step(kind_t'(2'h3)); c.cd_abort <= 1'h1; fire(8'h00);
        rd(32'h0000_0004, {cnt[15:0], 16'h0009}, 1'h0);
        apb(1'h1, 32'h0000_0004, 32'h0000_0000);
        rd(32'h0000_0004, 32'h0000_0009, 1'h0);
        final_report();
    end
endmodule
